// *** bench/sleep_wakeup_control_test.sv ***
`timescale 1ns/1ns
`include "swc_cfg.svh"
module sleep_wakeup_control_test;
  import swc_pkg::*;
  logic clk = 1'h0, rst = 1'h1, sleep = 1'h0, pin_n = 1'h1, pin_en = 1'h1;
  logic bor = 1'h0, bor_en = 1'h1, por = 1'h0, wdt = 1'h0, wdt_en = 1'h1;
  logic global_interrupt_enable = 1'h0, done, asleep, clk_en, fetch, preq, exec_pf, vec;
  logic dev_rst, wclr, rs;
  logic [14:0] pc = 15'h0000, pf_addr;
  logic [7:0] irq = 8'h00, irq_en = 8'hFF, pirq = 8'h00, pirq_en = 8'hFF;
  logic [7:0] alt = 8'h00, prun, b = 8'h01;
  logic [3:0] lag = 4'h0;
  swc_wake_t cause;
  int error_cnt = 0, samples_checked = 0, seed = 32'hA2A3959C, n;

  always #4 clk = ~clk;

  swc_top DUT (.CLK_I(clk), .RST_I(rst), .SLEEP_EXEC_I(sleep), .PC_I(pc),
    .EXT_RESET_PIN_N_I(pin_n), .EXT_RESET_EN_I(pin_en), .BROWNOUT_I(bor),
    .BROWNOUT_EN_I(bor_en), .POR_I(por), .WDT_TIMEOUT_I(wdt),
    .WDT_EN_I(wdt_en), .EXT_IRQ_I(irq), .EXT_IRQ_EN_I(irq_en),
    .PERIPH_IRQ_I(pirq), .PERIPH_IRQ_EN_I(pirq_en), .PERIPH_ALT_CLK_I(alt),
    .GLOBAL_INTERRUPT_ENABLE_I(global_interrupt_enable), .PREFETCH_DONE_I(done),
    .ASLEEP_O(asleep), .MAIN_CLK_EN_O(clk_en), .FETCH_EN_O(fetch),
    .PREFETCH_REQ_O(preq), .PREFETCH_ADDR_O(pf_addr),
    .EXEC_PREFETCHED_O(exec_pf), .VECTOR_ISR_O(vec),
    .DEVICE_RESET_O(dev_rst), .WDT_CLEAR_O(wclr), .PERIPH_RUN_O(prun),
    .WAKE_CAUSE_O(cause));

  swc_core_model core (.clk_i(clk), .rst_i(rst), .req_i(preq), .lag_i(lag),
    .done_o(done));

  // =====================================================
  // checking and closing
  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task conclude;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // =====================================================
  // stimulus: source c is 0 pin, 1 brown-out, 2 power-on, 3 watchdog,
  // 4 external irq, 5 peripheral irq
  task src(input int c, input logic on, input logic en);
    pin_n = !(on && c == 0);
    pin_en = !(c == 0 && !en);
    bor = on && c == 1;
    bor_en = !(c == 1 && !en);
    por = on && c == 2;
    wdt = on && c == 3;
    wdt_en = !(c == 3 && !en);
    irq = (on && c == 4) ? b : 8'h00;
    irq_en = (c == 4 && !en) ? ~b : 8'hFF;
    pirq = (on && c == 5) ? b : 8'h00;
    pirq_en = (c == 5 && !en) ? ~b : 8'hFF;
  endtask

  task go_sleep;
    @(negedge clk);
    pc = 15'($random(seed));
    alt = 8'($random(seed));
    lag = 4'($random(seed)) & 4'h3;
    sleep = 1'h1;
    @(negedge clk);
    sleep = 1'h0;
    chk(16'(preq), 16'h1);
    n = 0;
    while (asleep !== 1'h1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    chk(16'(asleep), 16'h1);
    chk(16'(clk_en), 16'h0);
    chk(16'(fetch), 16'h0);
    chk(16'(preq), 16'h0);
    chk(16'(pf_addr), 16'(15'(pc + 15'h1)));
    chk(16'(prun), 16'(alt));
  endtask

  task wake(input int c);
    b = 8'h01 << ($random(seed) & 7);
    rs = c < 3;
    // disabled source first: it must not end sleep
    if (c != 2)
    begin
      src(c, 1'h1, 1'h0);
      repeat (12) @(negedge clk);
      chk(16'(asleep), 16'h1);
    end
    src(c, 1'h1, 1'h1);
    n = 0;
    while (wclr !== 1'h1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    chk(16'(wclr), 16'h1);
    chk(16'(asleep), 16'h0);
    chk(16'(dev_rst), 16'(rs));
    chk(16'(exec_pf), 16'(!rs));
    chk(16'(cause), rs ? 16'h1 : 16'h2);
    src(c, 1'h0, 1'h1);
    @(negedge clk);
    chk(16'(vec), 16'(!rs && global_interrupt_enable));
    chk(16'(exec_pf), 16'h0);
    chk(16'(fetch), 16'(!rs && !global_interrupt_enable));
    chk(16'(wclr), 16'h0);
    chk(16'(dev_rst), 16'(rs));
    n = 2;
    while (rs && dev_rst === 1'h1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    if (rs)
      chk(16'(n - 1), 16'(`SWC_RST_CYC));
    repeat (8) @(negedge clk);
    chk(16'(fetch), 16'h1);
    chk(16'(prun), 16'hFF);
  endtask

  // =====================================================
  // main sequence
  initial
  begin
    repeat (16) @(negedge clk);
    chk(16'(clk_en), 16'h1);
    chk(16'(fetch), 16'h1);
    rst = 1'h0;
    repeat (6) @(negedge clk);
    for (int r = 0; r < 2; r++)
      for (int c = 0; c < 6; c++)
      begin
        // both global enable values reach every source over two rounds
        global_interrupt_enable = 1'(r ^ c);
        go_sleep;
        wake(c);
      end
    conclude;
  end

  // last-resort guard; every wait loop is bounded, so a hung handshake fails checks rather than stalling the run
  initial
  begin
    #60000;
    error_cnt++;
    conclude;
  end
endmodule

// *** bench/swc_core_model.sv ***
`timescale 1ns/1ns
// =====================================================
// processor core side: answers a prefetch request lag_i plus one cycles after it is raised
module swc_core_model
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic [3:0] lag_i,
  output logic done_o
);
  logic [3:0] cnt;
  // done is registered: it stays up one cycle after the request falls, never longer
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt <= 4'h0;
      done_o <= 1'h0;
    end
    else
    begin
      cnt <= req_i ? cnt + 4'h1 : 4'h0;
      done_o <= req_i && (cnt >= lag_i);
    end
  end
endmodule

// *** core/swc_sync.sv ***
`timescale 1ns/1ns
// three-flop synchroniser; a change is accepted once flops 2 and 3 agree
module swc_sync
#(
  parameter int W = 1
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  input wire logic [W-1:0] rst_val_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] q;
  logic [W-1:0] next_q;
  logic primed;

  always_comb
  begin
    next_q = q;
    for (int i = 0; i < W; i++)
    begin
      if (s2[i] == s3[i])
      begin
        next_q[i] = s3[i];
      end
    end
    if (!primed)
    begin
      next_q = rst_val_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
      primed <= 1'b0;
    end
    else
    begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
      primed <= 1'b1;
    end
  end

  assign q_o = q;
endmodule

// *** core/swc_top.sv ***
`timescale 1ns/1ns
`include "swc_cfg.svh"
module swc_top
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic SLEEP_EXEC_I,
  input wire logic [`SWC_PC_W-1:0] PC_I,
  input wire logic EXT_RESET_PIN_N_I,
  input wire logic EXT_RESET_EN_I,
  input wire logic BROWNOUT_I,
  input wire logic BROWNOUT_EN_I,
  input wire logic POR_I,
  input wire logic WDT_TIMEOUT_I,
  input wire logic WDT_EN_I,
  input wire logic [`SWC_IRQ_W-1:0] EXT_IRQ_I,
  input wire logic [`SWC_IRQ_W-1:0] EXT_IRQ_EN_I,
  input wire logic [`SWC_PERIPH_W-1:0] PERIPH_IRQ_I,
  input wire logic [`SWC_PERIPH_W-1:0] PERIPH_IRQ_EN_I,
  input wire logic [`SWC_PERIPH_W-1:0] PERIPH_ALT_CLK_I,
  input wire logic GLOBAL_INTERRUPT_ENABLE_I,
  input wire logic PREFETCH_DONE_I,
  output logic ASLEEP_O,
  output logic MAIN_CLK_EN_O,
  output logic FETCH_EN_O,
  output logic PREFETCH_REQ_O,
  output logic [`SWC_PC_W-1:0] PREFETCH_ADDR_O,
  output logic EXEC_PREFETCHED_O,
  output logic VECTOR_ISR_O,
  output logic DEVICE_RESET_O,
  output logic WDT_CLEAR_O,
  output logic [`SWC_PERIPH_W-1:0] PERIPH_RUN_O,
  output swc_pkg::swc_wake_t WAKE_CAUSE_O
);
  import swc_pkg::*;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  localparam int RCW = $clog2(`SWC_RST_CYC + 1);
  localparam int NIN = 6 + 2 * `SWC_IRQ_W + `SWC_PERIPH_W;

  // =====================================================
  // pin synchronisers (ext reset pin idles high)
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] sync_in;
  logic [NIN-1:0] sync_rst_val;
  logic ext_rst_n;
  logic bor_s;
  logic por_s;
  logic wdt_s;
  logic ext_rst_en_s;
  logic bor_en_s;
  logic [`SWC_IRQ_W-1:0] ext_irq_s;
  logic [`SWC_IRQ_W-1:0] ext_en_s;
  logic [`SWC_PERIPH_W-1:0] per_irq_s;

  assign raw_in = {EXT_RESET_PIN_N_I, BROWNOUT_I, POR_I, WDT_TIMEOUT_I,
                   EXT_RESET_EN_I, BROWNOUT_EN_I, EXT_IRQ_I, EXT_IRQ_EN_I,
                   PERIPH_IRQ_I};
  assign sync_rst_val = {1'b1, {(NIN - 1){1'b0}}};
  assign {ext_rst_n, bor_s, por_s, wdt_s, ext_rst_en_s, bor_en_s,
          ext_irq_s, ext_en_s, per_irq_s} = sync_in;

  swc_sync #(.W(NIN)) u_sync
  (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .d_i(raw_in),
    .rst_val_i(sync_rst_val),
    .q_o(sync_in)
  );

  // =====================================================
  // wake event classification
  logic reset_evt;
  logic resume_evt;

  always_comb
  begin
    reset_evt = (!ext_rst_n && ext_rst_en_s)
      || (bor_s && bor_en_s) || por_s;
    // individual enables only; global enable plays no part here
    resume_evt = (wdt_s && WDT_EN_I)
      || |(ext_irq_s & ext_en_s)
      || |(per_irq_s & PERIPH_IRQ_EN_I);
  end

  // =====================================================
  // sleep sequencer
  swc_state_t state;
  swc_state_t next_state;
  swc_wake_t cause;
  swc_wake_t next_cause;
  logic [`SWC_PC_W-1:0] pf_addr;
  logic [`SWC_PC_W-1:0] next_pf_addr;
  logic gie_at_wake;
  logic next_gie_at_wake;
  logic [RCW-1:0] rst_cnt;
  logic [RCW-1:0] next_rst_cnt;

  always_comb
  begin
    next_state = state;
    next_cause = cause;
    next_pf_addr = pf_addr;
    next_gie_at_wake = gie_at_wake;
    next_rst_cnt = rst_cnt;
    unique case (state)
      SWC_RUN:
      begin
        if (reset_evt)
        begin
          next_state = SWC_RESET;
          next_rst_cnt = RCW'(`SWC_RST_CYC);
        end
        else if (SLEEP_EXEC_I)
        begin
          next_state = SWC_ENTER;
          next_pf_addr = PC_I + `SWC_PC_W'(1);
          next_cause = SWC_WAKE_NONE;
        end
      end
      SWC_ENTER:
      begin
        if (PREFETCH_DONE_I)
        begin
          next_state = SWC_ASLEEP;
        end
      end
      SWC_ASLEEP:
      begin
        if (reset_evt)
        begin
          next_state = SWC_RESET;
          next_cause = SWC_WAKE_RESET;
          next_rst_cnt = RCW'(`SWC_RST_CYC);
        end
        else if (resume_evt)
        begin
          next_state = SWC_RESUME;
          next_cause = SWC_WAKE_RESUME;
          next_gie_at_wake = GLOBAL_INTERRUPT_ENABLE_I;
        end
      end
      SWC_RESUME:
      begin
        // prefetched instruction runs first in both cases
        next_state = gie_at_wake ? SWC_VECTOR : SWC_RUN;
      end
      SWC_VECTOR:
      begin
        next_state = SWC_RUN;
      end
      SWC_RESET:
      begin
        if (rst_cnt > RCW'(1))
        begin
          next_rst_cnt = rst_cnt - RCW'(1);
        end
        else if (!reset_evt)
        begin
          next_state = SWC_RUN;
          next_rst_cnt = '0;
        end
      end
      default:
      begin
        next_state = SWC_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state <= SWC_RUN;
      cause <= SWC_WAKE_NONE;
      pf_addr <= `SWC_PC_RST;
      gie_at_wake <= 1'b0;
      rst_cnt <= '0;
    end
    else
    begin
      state <= next_state;
      cause <= next_cause;
      pf_addr <= next_pf_addr;
      gie_at_wake <= next_gie_at_wake;
      rst_cnt <= next_rst_cnt;
    end
  end

  // =====================================================
  // registered outputs
  logic wake_exit;
  assign wake_exit = (state == SWC_ASLEEP) && (reset_evt || resume_evt);

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      ASLEEP_O <= 1'b0;
      MAIN_CLK_EN_O <= 1'b1;
      FETCH_EN_O <= 1'b1;
      PREFETCH_REQ_O <= 1'b0;
      PREFETCH_ADDR_O <= `SWC_PC_RST;
      EXEC_PREFETCHED_O <= 1'b0;
      VECTOR_ISR_O <= 1'b0;
      DEVICE_RESET_O <= 1'b0;
      WDT_CLEAR_O <= 1'b0;
      PERIPH_RUN_O <= '1;
      WAKE_CAUSE_O <= SWC_WAKE_NONE;
    end
    else
    begin
      ASLEEP_O <= next_state == SWC_ASLEEP;
      MAIN_CLK_EN_O <= next_state != SWC_ASLEEP;
      FETCH_EN_O <= next_state == SWC_RUN;
      PREFETCH_REQ_O <= next_state == SWC_ENTER;
      PREFETCH_ADDR_O <= next_pf_addr;
      EXEC_PREFETCHED_O <= next_state == SWC_RESUME;
      VECTOR_ISR_O <= next_state == SWC_VECTOR;
      DEVICE_RESET_O <= next_state == SWC_RESET;
      WDT_CLEAR_O <= wake_exit;
      // alternate-clock peripherals keep running asleep
      PERIPH_RUN_O <= (next_state == SWC_ASLEEP)
        ? PERIPH_ALT_CLK_I : '1;
      WAKE_CAUSE_O <= next_cause;
    end
  end

  // =====================================================
  // checks
  wdt_on_wake_a: assert property (
    wake_exit |=> WDT_CLEAR_O)
    else $error("watchdog not cleared on wake");
  reset_wake_a: assert property (
    (state == SWC_ASLEEP && reset_evt)
    |=> DEVICE_RESET_O && !EXEC_PREFETCHED_O)
    else $error("reset wake did not reset");
  resume_wake_a: assert property (
    (state == SWC_ASLEEP && !reset_evt && resume_evt)
    |=> EXEC_PREFETCHED_O && !DEVICE_RESET_O)
    else $error("resume wake wrong");
  gie_clear_a: assert property (
    (EXEC_PREFETCHED_O && !gie_at_wake) |=> !VECTOR_ISR_O && FETCH_EN_O)
    else $error("vectored with global enable clear");
  gie_set_a: assert property (
    (EXEC_PREFETCHED_O && gie_at_wake) |=> VECTOR_ISR_O ##1 FETCH_EN_O)
    else $error("isr call missing after prefetched op");
  prefetch_addr_a: assert property (
    (state == SWC_RUN && SLEEP_EXEC_I && !reset_evt)
    |=> PREFETCH_REQ_O && PREFETCH_ADDR_O == $past(PC_I) + `SWC_PC_W'(1))
    else $error("prefetch address not pc plus one");
  masked_irq_a: assert property (
    (state == SWC_ASLEEP && !reset_evt && !(wdt_s && WDT_EN_I)
     && !(|(ext_irq_s & ext_en_s)) && !(|(per_irq_s & PERIPH_IRQ_EN_I)))
    |=> ASLEEP_O)
    else $error("woke on disabled source");
  clk_gated_a: assert property (
    ASLEEP_O |-> !MAIN_CLK_EN_O && !FETCH_EN_O)
    else $error("clock or fetch live in sleep");
  alt_clk_run_a: assert property (
    ASLEEP_O |-> PERIPH_RUN_O == $past(PERIPH_ALT_CLK_I))
    else $error("alternate-clock peripheral stopped");
  reset_len_a: assert property (
    $rose(DEVICE_RESET_O) |-> DEVICE_RESET_O [*8])
    else $error("reset pulse too short");

  sleep_irq_c: cover property (ASLEEP_O ##[1:50] VECTOR_ISR_O);
  sleep_noisr_c: cover property (EXEC_PREFETCHED_O && !gie_at_wake);
  sleep_reset_c: cover property (ASLEEP_O ##1 DEVICE_RESET_O);
endmodule

// *** include/swc_cfg.svh ***
`ifndef SWC_CFG_SVH
`define SWC_CFG_SVH
// Function
// - pin reset, brown-out, power-on, watchdog or an irq ends sleep.
// - a pin, brown-out or power-on wake-up gives a full device reset.
// - a watchdog or interrupt wake-up resumes execution with no reset.
// - while sleep executes, the instruction at pc plus one is prefetched.
// - an interrupt wakes the device only if its own enable bit is set.
// - an enabled interrupt wakes the device whatever the global enable.
// - global enable clear: execution goes on after sleep with no vector.
// - global enable set: prefetched op runs, then the routine is called.
// - the windowed watchdog is cleared on every exit from sleep.
// - peripherals on a clock other than the main clock may run in sleep.

// =====================================================
// widths and reset values
`define SWC_PC_W 15
`define SWC_IRQ_W 8
`define SWC_PERIPH_W 8
`define SWC_PC_RST 15'h0000
`define SWC_IRQ_NONE 8'h00
// reset pulse length in ns and cycles at 8 ns
`define SWC_RST_NS 64
`define SWC_CLK_NS 8
`define SWC_RST_CYC ((`SWC_RST_NS + `SWC_CLK_NS - 1) / `SWC_CLK_NS)
`endif

// *** include/swc_pkg.sv ***
package swc_pkg;
  // gray codes along run, sleep_entry, asleep, wake, isr path
  typedef enum logic [2:0] {
    SWC_RUN = 3'h0,
    SWC_ENTER = 3'h1,
    SWC_ASLEEP = 3'h3,
    SWC_RESUME = 3'h2,
    SWC_VECTOR = 3'h6,
    SWC_RESET = 3'h7
  } swc_state_t;
  typedef enum logic [1:0] {
    SWC_WAKE_NONE = 2'h0,
    SWC_WAKE_RESET = 2'h1,
    SWC_WAKE_RESUME = 2'h2
  } swc_wake_t;
endpackage
